// ==== hdl/clk_pm_cfg.svh ====
// register offsets, field positions, reset values and timing counts
// for the system clock and power mode controller; included by bare name
//
// Notes on behaviour
// - selector codes 000..110 pick fast clock /1../64, 111 picks sub clock
// - during halt the fast idle enable keeps fast oscillator on or off
// - halt with both idle enables 0 enters sleep, fast and sub clocks off
// - halt with fast 0, slow 1 enters sub-clock idle: sub clock only
// - halt with both idle enables 1 enters dual idle: both clocks run
// - halt with fast 1, slow 0 enters fast idle: fast clock only
// - power-down stops execution and leaves registers and ports unchanged
// - power-down entry sets power-down flag, clears watchdog timeout flag
// - power-down entry clears the watchdog counter; it resumes if enabled
// - fast rc frequency field: 00 4MHz, 01 8MHz, 10 12MHz, 11 4MHz
// - fast rc enable bit runs (1) or stops (0) the fast oscillator; 0 stops it only while the sub clock is active
// - enabling fast rc clears stable flag, set again once stable
// - fast/slow only via selector; sleep or idle chosen at each halt
// - switch to sub clock completes only once slow rc is stable
// - unimplemented control register bits read as zero
// - in sleep the slow rc keeps running while the watchdog is enabled
`ifndef CLK_PM_CFG_SVH
`define CLK_PM_CFG_SVH

// byte addresses on the register bus
`define ADDR_SYS_CLK_CTRL 12'h000
`define ADDR_FAST_RC_CTRL 12'h004
`define ADDR_POWER_STATUS 12'h008
`define ADDR_IRQ_STATUS 12'h00c
`define ADDR_IRQ_ENABLE 12'h010
`define ADDR_IRQ_CLEAR 12'h014

// system_clock_control fields
`define SYS_SEL_MSB 7
`define SYS_SEL_LSB 5
`define SYS_FAST_IDLE_BIT 1
`define SYS_SLOW_IDLE_BIT 0
`define SYS_CTRL_RESET 8'h00

// high_speed_rc_control fields
`define HRC_FREQ_MSB 3
`define HRC_FREQ_LSB 2
`define HRC_STABLE_BIT 1
`define HRC_ENABLE_BIT 0
`define HRC_RESET 8'h01

// selector code of the sub clock and the aliased frequency code
`define SEL_SUB_CLOCK 3'h7
`define FREQ_ALIAS_CODE 2'h3
`define FREQ_4MHZ_CODE 2'h0

// interrupt event bits
`define IRQ_POWER_DOWN 0
`define IRQ_FAST_STABLE 1
`define IRQ_CLK_SWITCH 2
`define IRQ_WAKE 3

// fast rc settling guard after it is started
`define SYS_CLK_PERIOD_NS 8
`define FAST_RC_SETTLE_NS 1000

`endif

// ==== hdl/clk_pm_pkg.sv ====
// types shared by the system clock and power mode controller
// assumes the configuration header carries all numeric constants
package clk_pm_pkg;

    typedef enum logic [2:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_IDLE_SUB,
        MODE_IDLE_BOTH,
        MODE_IDLE_FAST
    } power_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic cpuRun;
        logic [2:0] sysclkSource;
        logic fastRcRun;
        logic [1:0] fastRcFreq;
        logic subClockRun;
        logic slowRcRun;
        logic wdtClear;
    } clk_ctl_t;

    typedef struct packed {
        logic [2:0] sysclkSelect;
        logic fastOscIdleEnable;
        logic slowOscIdleEnable;
        logic [1:0] fastRcFreqSelect;
        logic fastRcEnable;
        logic fastRcStableFlag;
        logic [2:0] activeSelect;
        power_mode_t mode;
        logic powerDownFlag;
        logic watchdogTimeoutFlag;
        logic [3:0] irqStatus;
        logic [3:0] irqEnable;
        logic [7:0] settleCount;
        logic [1:0] fastStableSync;
        logic [1:0] slowStableSync;
        clk_ctl_t ctl;
        apb_rsp_t rsp;
        logic irq;
    } pm_state_t;

endpackage

// ==== hdl/system_clock_power_modes.sv ====
// system clock selection and low power mode control with apb registers
// assumes halt, wake and watchdog strobes come from logic on sys_clk and
// the oscillator stable levels arrive asynchronously from analog cells
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "clk_pm_cfg.svh"

module system_clock_power_modes (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire clk_pm_pkg::apb_req_t apbReq,
    output clk_pm_pkg::apb_rsp_t apbRsp,
    input wire logic haltReq,
    input wire logic wakeReq,
    input wire logic wdtEnable,
    input wire logic wdtTimeout,
    input wire logic wdtClearInstr,
    input wire logic fastRcStableRaw,
    input wire logic slowRcStableRaw,
    output clk_pm_pkg::clk_ctl_t clkCtl,
    output logic irq
);

    localparam int SettleCycles = (`FAST_RC_SETTLE_NS +
        `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS;
    localparam logic [7:0] SettleLast = 8'(SettleCycles);
    // reset images of the two control registers
    localparam logic [7:0] SysCtlReset = `SYS_CTRL_RESET;
    localparam logic [7:0] FastRcReset = `HRC_RESET;

    clk_pm_pkg::pm_state_t state_reg;
    clk_pm_pkg::pm_state_t state_next;

    // bus phase decode, shared by the next-state logic and the checks
    logic setupPhase;
    logic accessDone;
    logic wrSysCtl;
    logic wrHrc;
    assign setupPhase = apbReq.psel & ~apbReq.penable;
    assign accessDone = apbReq.psel & apbReq.penable & state_reg.rsp.pready;
    assign wrSysCtl = accessDone & apbReq.pwrite &
        (apbReq.paddr == `ADDR_SYS_CLK_CTRL);
    assign wrHrc = accessDone & apbReq.pwrite &
        (apbReq.paddr == `ADDR_FAST_RC_CTRL);

    // next state: registers, mode machine, oscillator control, interrupts
    always_comb begin
        logic [31:0] rdData;
        logic mapped;
        logic enterDown;
        logic [3:0] events;
        logic fastRun;
        logic halted;
        rdData = 32'h0000_0000;
        mapped = 1'b1;
        enterDown = 1'b0;
        events = 4'h0;
        fastRun = 1'b0;
        halted = 1'b0;
        state_next = state_reg;

        // oscillator stable levels: second stage is the only one read
        state_next.fastStableSync = {state_reg.fastStableSync[0],
            fastRcStableRaw};
        state_next.slowStableSync = {state_reg.slowStableSync[0],
            slowRcStableRaw};

        // register writes at the completing access edge
        if (wrSysCtl) begin
            state_next.sysclkSelect =
                apbReq.pwdata[`SYS_SEL_MSB:`SYS_SEL_LSB];
            state_next.fastOscIdleEnable =
                apbReq.pwdata[`SYS_FAST_IDLE_BIT];
            state_next.slowOscIdleEnable =
                apbReq.pwdata[`SYS_SLOW_IDLE_BIT];
        end
        if (wrHrc) begin
            state_next.fastRcFreqSelect =
                apbReq.pwdata[`HRC_FREQ_MSB:`HRC_FREQ_LSB];
            state_next.fastRcEnable = apbReq.pwdata[`HRC_ENABLE_BIT];
        end
        if (accessDone && apbReq.pwrite &&
            apbReq.paddr == `ADDR_IRQ_ENABLE) begin
            state_next.irqEnable = apbReq.pwdata[3:0];
        end

        // active clock source: sub clock waits for slow rc to settle
        if (state_reg.sysclkSelect != `SEL_SUB_CLOCK) begin
            state_next.activeSelect = state_reg.sysclkSelect;
        end else if (state_reg.slowStableSync[1]) begin
            state_next.activeSelect = `SEL_SUB_CLOCK;
        end
        events[`IRQ_CLK_SWITCH] =
            state_next.activeSelect != state_reg.activeSelect;

        // power mode machine: halt picks the mode from the idle enables
        unique case (state_reg.mode)
            clk_pm_pkg::MODE_RUN: begin
                if (haltReq) begin
                    enterDown = 1'b1;
                    unique case ({state_reg.fastOscIdleEnable,
                        state_reg.slowOscIdleEnable})
                        2'b00: state_next.mode = clk_pm_pkg::MODE_SLEEP;
                        2'b01:
                            state_next.mode = clk_pm_pkg::MODE_IDLE_SUB;
                        2'b11:
                            state_next.mode = clk_pm_pkg::MODE_IDLE_BOTH;
                        2'b10:
                            state_next.mode = clk_pm_pkg::MODE_IDLE_FAST;
                    endcase
                end
            end
            clk_pm_pkg::MODE_SLEEP, clk_pm_pkg::MODE_IDLE_SUB,
            clk_pm_pkg::MODE_IDLE_BOTH, clk_pm_pkg::MODE_IDLE_FAST: begin
                if (wakeReq) begin
                    state_next.mode = clk_pm_pkg::MODE_RUN;
                    events[`IRQ_WAKE] = 1'b1;
                end
            end
            default: state_next.mode = clk_pm_pkg::MODE_RUN;
        endcase
        events[`IRQ_POWER_DOWN] = enterDown;
        halted = state_next.mode != clk_pm_pkg::MODE_RUN;

        // status flags: a setting event wins over a clearing one
        if (wdtClearInstr) begin
            state_next.powerDownFlag = 1'b0;
        end
        if (enterDown) begin
            state_next.powerDownFlag = 1'b1;
            state_next.watchdogTimeoutFlag = 1'b0;
        end
        if (wdtTimeout) begin
            state_next.watchdogTimeoutFlag = 1'b1;
        end

        // fast rc runs on its enable or while a fast clock is active, or during halt on the idle enable
        if (halted) begin
            fastRun = state_next.fastOscIdleEnable;
        end else begin
            fastRun = state_next.fastRcEnable |
                (state_next.activeSelect != `SEL_SUB_CLOCK);
        end

        // stable flag: cleared on enable, set after settle and report
        if (!state_next.fastRcEnable || !fastRun) begin
            state_next.settleCount = 8'h00;
            state_next.fastRcStableFlag = 1'b0;
        end else if (wrHrc && !state_reg.fastRcEnable) begin
            state_next.settleCount = 8'h00;
            state_next.fastRcStableFlag = 1'b0;
        end else if (state_reg.settleCount != SettleLast) begin
            state_next.settleCount = state_reg.settleCount + 8'h01;
        end else if (state_reg.fastStableSync[1]) begin
            state_next.fastRcStableFlag = 1'b1;
        end
        events[`IRQ_FAST_STABLE] = state_next.fastRcStableFlag &
            ~state_reg.fastRcStableFlag;

        // clock control outputs, registered from the next state
        state_next.ctl.cpuRun = ~halted;
        state_next.ctl.sysclkSource = state_next.activeSelect;
        state_next.ctl.fastRcRun = fastRun;
        state_next.ctl.fastRcFreq =
            (state_next.fastRcFreqSelect == `FREQ_ALIAS_CODE) ?
            `FREQ_4MHZ_CODE : state_next.fastRcFreqSelect;
        unique case (state_next.mode)
            clk_pm_pkg::MODE_SLEEP: begin
                state_next.ctl.subClockRun = 1'b0;
                state_next.ctl.slowRcRun = wdtEnable;
            end
            clk_pm_pkg::MODE_IDLE_FAST: begin
                state_next.ctl.subClockRun = 1'b0;
                state_next.ctl.slowRcRun = 1'b1;
            end
            default: begin
                state_next.ctl.subClockRun = 1'b1;
                state_next.ctl.slowRcRun = 1'b1;
            end
        endcase
        state_next.ctl.wdtClear = enterDown;

        // interrupt status: clear by writing ones, events win
        if (accessDone && apbReq.pwrite &&
            apbReq.paddr == `ADDR_IRQ_CLEAR) begin
            state_next.irqStatus = state_reg.irqStatus &
                ~apbReq.pwdata[3:0];
        end
        state_next.irqStatus = state_next.irqStatus | events;
        state_next.irq = |(state_next.irqStatus & state_next.irqEnable);

        // read mux, sampled in the setup cycle
        unique case (apbReq.paddr)
            `ADDR_SYS_CLK_CTRL: begin
                rdData[`SYS_SEL_MSB:`SYS_SEL_LSB] = state_reg.sysclkSelect;
                rdData[`SYS_FAST_IDLE_BIT] = state_reg.fastOscIdleEnable;
                rdData[`SYS_SLOW_IDLE_BIT] = state_reg.slowOscIdleEnable;
            end
            `ADDR_FAST_RC_CTRL: begin
                rdData[`HRC_FREQ_MSB:`HRC_FREQ_LSB] =
                    state_reg.fastRcFreqSelect;
                rdData[`HRC_STABLE_BIT] = state_reg.fastRcStableFlag;
                rdData[`HRC_ENABLE_BIT] = state_reg.fastRcEnable;
            end
            `ADDR_POWER_STATUS: begin
                rdData[0] = state_reg.powerDownFlag;
                rdData[1] = state_reg.watchdogTimeoutFlag;
                rdData[4:2] = state_reg.activeSelect;
                rdData[5] = state_reg.mode != clk_pm_pkg::MODE_RUN;
            end
            `ADDR_IRQ_STATUS: rdData[3:0] = state_reg.irqStatus;
            `ADDR_IRQ_ENABLE: rdData[3:0] = state_reg.irqEnable;
            `ADDR_IRQ_CLEAR: rdData = 32'h0000_0000;
            default: mapped = 1'b0;
        endcase

        // one wait-free access phase: pready for exactly one cycle
        state_next.rsp.pready = setupPhase;
        state_next.rsp.pslverr = setupPhase & ~mapped;
        state_next.rsp.prdata = (setupPhase && !apbReq.pwrite) ?
            rdData : 32'h0000_0000;
    end

    // state register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
            state_reg.mode <= clk_pm_pkg::MODE_RUN;
            state_reg.sysclkSelect <=
                SysCtlReset[`SYS_SEL_MSB:`SYS_SEL_LSB];
            state_reg.fastRcEnable <= FastRcReset[`HRC_ENABLE_BIT];
            state_reg.ctl.cpuRun <= 1'b1;
            state_reg.ctl.fastRcRun <= 1'b1;
            state_reg.ctl.subClockRun <= 1'b1;
            state_reg.ctl.slowRcRun <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign apbRsp = state_reg.rsp;
    assign clkCtl = state_reg.ctl;
    assign irq = state_reg.irq;

    // checks on the controller's own behaviour
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    logic runHalt;
    assign runHalt = (state_reg.mode == clk_pm_pkg::MODE_RUN) & haltReq;

    property p_fast_select;
        (state_reg.sysclkSelect != `SEL_SUB_CLOCK) |=>
            (state_reg.activeSelect == $past(state_reg.sysclkSelect));
    endproperty
    a_fast_select: assert property (p_fast_select)
        else $error("active clock source does not follow selector");

    property p_sub_waits;
        (state_reg.sysclkSelect == `SEL_SUB_CLOCK &&
            !state_reg.slowStableSync[1] &&
            state_reg.activeSelect != `SEL_SUB_CLOCK) |=>
            (state_reg.activeSelect != `SEL_SUB_CLOCK);
    endproperty
    a_sub_waits: assert property (p_sub_waits)
        else $error("sub clock switch completed before slow rc stable");

    property p_sleep;
        (runHalt && !state_reg.fastOscIdleEnable &&
            !state_reg.slowOscIdleEnable) |=>
            (state_reg.mode == clk_pm_pkg::MODE_SLEEP &&
            !clkCtl.subClockRun && !clkCtl.fastRcRun && !clkCtl.cpuRun);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep entry wrong");

    property p_idle_sub;
        (runHalt && !state_reg.fastOscIdleEnable &&
            state_reg.slowOscIdleEnable) |=>
            (state_reg.mode == clk_pm_pkg::MODE_IDLE_SUB &&
            clkCtl.subClockRun && !clkCtl.fastRcRun);
    endproperty
    a_idle_sub: assert property (p_idle_sub)
        else $error("sub-clock idle entry wrong");

    property p_idle_dual;
        (runHalt && state_reg.fastOscIdleEnable &&
            state_reg.slowOscIdleEnable) |=>
            (state_reg.mode == clk_pm_pkg::MODE_IDLE_BOTH &&
            clkCtl.subClockRun && clkCtl.fastRcRun);
    endproperty
    a_idle_dual: assert property (p_idle_dual)
        else $error("dual-clock idle entry wrong");

    property p_idle_fast_only;
        (runHalt && state_reg.fastOscIdleEnable &&
            !state_reg.slowOscIdleEnable) |=>
            (state_reg.mode == clk_pm_pkg::MODE_IDLE_FAST &&
            !clkCtl.subClockRun && clkCtl.fastRcRun);
    endproperty
    a_idle_fast_only: assert property (p_idle_fast_only)
        else $error("fast-clock idle entry wrong");

    property p_held;
        (state_reg.mode != clk_pm_pkg::MODE_RUN && !wrSysCtl) |=>
            $stable(state_reg.sysclkSelect);
    endproperty
    a_held: assert property (p_held)
        else $error("control register changed while powered down");

    property p_flags;
        (runHalt && !wdtTimeout) |=>
            (state_reg.powerDownFlag && !state_reg.watchdogTimeoutFlag);
    endproperty
    a_flags: assert property (p_flags)
        else $error("power-down flags not updated on entry");

    property p_wdt_clear;
        runHalt |=> clkCtl.wdtClear ##1 !clkCtl.wdtClear;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear)
        else $error("watchdog clear pulse missing or too long");

    property p_halt_only;
        (state_reg.mode == clk_pm_pkg::MODE_RUN && !haltReq) |=>
            (state_reg.mode == clk_pm_pkg::MODE_RUN);
    endproperty
    a_halt_only: assert property (p_halt_only)
        else $error("power mode left run without halt");

    property p_freq_alias;
        clkCtl.fastRcFreq != `FREQ_ALIAS_CODE;
    endproperty
    a_freq_alias: assert property (p_freq_alias)
        else $error("aliased frequency code reached oscillator");

    property p_idle_fast;
        (state_reg.mode != clk_pm_pkg::MODE_RUN && !wakeReq) |=>
            (clkCtl.fastRcRun == state_reg.fastOscIdleEnable);
    endproperty
    a_idle_fast: assert property (p_idle_fast)
        else $error("fast oscillator ignores idle enable in halt");

    property p_stable_restart;
        (wrHrc && !state_reg.fastRcEnable &&
            apbReq.pwdata[`HRC_ENABLE_BIT]) |=>
            !state_reg.fastRcStableFlag [*2];
    endproperty
    a_stable_restart: assert property (p_stable_restart)
        else $error("stable flag not cleared when fast rc enabled");

    property p_stable_off;
        !state_reg.fastRcEnable |-> !state_reg.fastRcStableFlag;
    endproperty
    a_stable_off: assert property (p_stable_off)
        else $error("stable flag set while fast rc disabled");

    property p_osc_off;
        (!state_reg.fastRcEnable && !wrHrc && !haltReq &&
            state_reg.mode == clk_pm_pkg::MODE_RUN &&
            state_reg.sysclkSelect == `SEL_SUB_CLOCK &&
            state_reg.activeSelect == `SEL_SUB_CLOCK) |=>
            !clkCtl.fastRcRun;
    endproperty
    a_osc_off: assert property (p_osc_off)
        else $error("fast rc runs while disabled in slow mode");

    property p_sleep_slow_rc;
        (state_reg.mode == clk_pm_pkg::MODE_SLEEP && !wakeReq &&
            wdtEnable) |=> clkCtl.slowRcRun;
    endproperty
    a_sleep_slow_rc: assert property (p_sleep_slow_rc)
        else $error("slow rc stopped in sleep with watchdog enabled");

    property p_unused_zero;
        (setupPhase && !apbReq.pwrite &&
            apbReq.paddr == `ADDR_SYS_CLK_CTRL) |=>
            (apbRsp.pready && apbRsp.prdata[31:8] == 24'h000000 &&
            apbRsp.prdata[4:2] == 3'h0);
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unimplemented control bits not zero");

    c_sleep_wake: cover property (state_reg.mode ==
        clk_pm_pkg::MODE_SLEEP ##1 wakeReq ##1
        state_reg.mode == clk_pm_pkg::MODE_RUN);
    c_to_sub: cover property (state_reg.activeSelect != `SEL_SUB_CLOCK
        ##1 state_reg.activeSelect == `SEL_SUB_CLOCK);
    c_stable: cover property (!state_reg.fastRcStableFlag
        ##1 state_reg.fastRcStableFlag);
    c_irq: cover property (!irq ##1 irq);

endmodule

// ==== verif/system_clock_power_modes_test.sv ====
// self-checking bench for the system clock and power mode controller
// assumes the design header and package are compiled ahead of this file
`timescale 1ns/1ps
`include "clk_pm_cfg.svh"

module system_clock_power_modes_test;
    logic sys_clk;
    logic resetn;
    clk_pm_pkg::apb_req_t apbReq;
    clk_pm_pkg::apb_rsp_t apbRsp;
    clk_pm_pkg::clk_ctl_t clkCtl;
    logic haltReq, wakeReq, wdtEnable, wdtTimeout, wdtClearInstr;
    logic fastRcStableRaw, slowRcStableRaw, irq;
    int errorCnt;
    int nChecks;
    logic [31:0] rdat;
    logic err;

    system_clock_power_modes dut (
        .sys_clk(sys_clk), .resetn(resetn), .apbReq(apbReq),
        .apbRsp(apbRsp), .haltReq(haltReq), .wakeReq(wakeReq),
        .wdtEnable(wdtEnable), .wdtTimeout(wdtTimeout),
        .wdtClearInstr(wdtClearInstr), .fastRcStableRaw(fastRcStableRaw),
        .slowRcStableRaw(slowRcStableRaw), .clkCtl(clkCtl), .irq(irq)
    );

    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // compare any result, zero extended to a word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        nChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge sys_clk);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= wr;
        apbReq.paddr <= a;
        apbReq.pwdata <= wd;
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 50);
        rd = apbRsp.prdata;
        er = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        if (n >= 50) begin
            chk(32'h0, 32'h1, "no pready");
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask

    // one-cycle strobe of {halt, wake, timeout, clear}; returns settled
    task automatic strobe(input logic [3:0] m);
        @(posedge sys_clk);
        {haltReq, wakeReq, wdtTimeout, wdtClearInstr} <= m;
        @(posedge sys_clk);
        {haltReq, wakeReq, wdtTimeout, wdtClearInstr} <= 4'h0;
        @(negedge sys_clk);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    initial begin
        #400000;
        errorCnt++;
        report_and_stop;
    end

    initial begin
        int i, n;
        logic [1:0] en;
        sys_clk = 1'b0;
        resetn = 1'b0;
        apbReq = '0;
        {haltReq, wakeReq, wdtTimeout, wdtClearInstr} = 4'h0;
        wdtEnable = 1'b1;
        fastRcStableRaw = 1'b1;
        slowRcStableRaw = 1'b0;
        errorCnt = 0;
        nChecks = 0;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        // reset values and unimplemented bits
        rd(`ADDR_SYS_CLK_CTRL, rdat);
        chk(rdat, 32'h0, "sys ctl reset");
        wr(`ADDR_SYS_CLK_CTRL, 32'h1f);
        rd(`ADDR_SYS_CLK_CTRL, rdat);
        chk(rdat, 32'h03, "sys ctl loose bits");
        wr(`ADDR_FAST_RC_CTRL, 32'hfd);
        rd(`ADDR_FAST_RC_CTRL, rdat);
        chk(rdat & 32'hfffffffd, 32'h0d, "hrc loose bits");
        apb(1'b0, 12'h018, 32'h0, rdat, err);
        chk({rdat[30:0], err}, 32'h1, "unmapped read");
        // frequency codes, 11 aliases 4MHz
        for (i = 0; i < 4; i++) begin
            wr(`ADDR_FAST_RC_CTRL, (i << 2) | 1);
            idle(2);
            chk(clkCtl.fastRcFreq, (i == 3) ? 0 : i, "freq");
        end
        // stable flag: zero while disabled, restarts on enable
        wr(`ADDR_FAST_RC_CTRL, 32'h0);
        rd(`ADDR_FAST_RC_CTRL, rdat);
        chk(rdat, 32'h0, "stable while off");
        wr(`ADDR_FAST_RC_CTRL, 32'h1);
        rd(`ADDR_FAST_RC_CTRL, rdat);
        chk(rdat, 32'h1, "stable cleared on enable");
        n = 0;
        while (rdat[1] !== 1'b1 && n < 200) begin
            rd(`ADDR_FAST_RC_CTRL, rdat);
            n++;
        end
        chk(rdat, 32'h3, "stable set");
        // selector codes for the fast clock and the sub clock
        for (i = 0; i < 7; i++) begin
            wr(`ADDR_SYS_CLK_CTRL, i << 5);
            idle(2);
            chk(clkCtl.sysclkSource, i, "fast select");
        end
        wr(`ADDR_SYS_CLK_CTRL, 32'he0);
        idle(10);
        chk(clkCtl.sysclkSource, 6, "sub waits for slow rc");
        @(posedge sys_clk);
        slowRcStableRaw <= 1'b1;
        idle(6);
        chk(clkCtl.sysclkSource, 7, "sub select");
        // fast rc enable while running from the sub clock
        wr(`ADDR_FAST_RC_CTRL, 32'h0);
        idle(2);
        chk(clkCtl.fastRcRun, 0, "fast rc off");
        wr(`ADDR_FAST_RC_CTRL, 32'h1);
        idle(2);
        chk(clkCtl.fastRcRun, 1, "fast rc on");
        // halt in every idle enable pair, sleep twice
        wr(`ADDR_IRQ_CLEAR, 32'hf);
        wr(`ADDR_IRQ_ENABLE, 32'h1);
        for (i = 0; i < 5; i++) begin
            en = i[1:0];
            wr(`ADDR_SYS_CLK_CTRL, 32'he0 | en);
            wdtEnable <= (i != 4);
            strobe(4'h1);
            strobe(4'h2);
            rd(`ADDR_POWER_STATUS, rdat);
            chk(rdat & 3, 2, "flags before halt");
            strobe(4'h8);
            chk(clkCtl.cpuRun, 0, "cpu stopped");
            chk(clkCtl.fastRcRun, en[1], "fast osc");
            chk(clkCtl.subClockRun, en[0], "sub clock");
            chk(clkCtl.slowRcRun, (en == 0) ? (i != 4) : 1, "slow rc");
            chk(clkCtl.wdtClear, 1, "wdt clear");
            idle(1);
            chk(clkCtl.wdtClear, 0, "wdt clear pulse");
            rd(`ADDR_POWER_STATUS, rdat);
            chk(rdat & 3, 1, "flags after halt");
            rd(`ADDR_SYS_CLK_CTRL, rdat);
            chk(rdat, 32'he0 | en, "sys ctl kept");
            strobe(4'h4);
            chk(clkCtl.cpuRun, 1, "woken");
        end
        // interrupt raised, masked, cleared
        chk(irq, 1, "irq raised");
        wr(`ADDR_IRQ_ENABLE, 32'h0);
        idle(2);
        chk(irq, 0, "irq masked");
        wr(`ADDR_IRQ_ENABLE, 32'h1);
        wr(`ADDR_IRQ_CLEAR, 32'hf);
        rd(`ADDR_IRQ_STATUS, rdat);
        chk(rdat, 32'h0, "irq status cleared");
        idle(2);
        chk(irq, 0, "irq cleared");
        report_and_stop;
    end
endmodule
